// >>> sos_map.vh
`ifndef SOS_MAP_VH
`define SOS_MAP_VH

// Register byte addresses.
`define SOS_ADDR_CTRL 8'h00
`define SOS_ADDR_FUNC 8'h04
`define SOS_ADDR_FREQ_THR 8'h08
`define SOS_ADDR_LOAD_THR 8'h0c
`define SOS_ADDR_FB_LIMIT 8'h10
`define SOS_ADDR_START_FREQ 8'h14
`define SOS_ADDR_LOGIC 8'h18
`define SOS_ADDR_OUT_STATE 8'h1c
`define SOS_ADDR_INT_STATUS 8'h20
`define SOS_ADDR_INT_MASK 8'h24

// Control register fields.
`define SOS_CTRL_ANALOG_SEL 0
`define SOS_CTRL_CONTACT_A 4
`define SOS_CTRL_CONTACT_B 5
`define SOS_CTRL_RELAY_FUNC 8
`define SOS_CTRL_RELAY_VALUE 9
`define SOS_CTRL_WD_FAULT 12
`define SOS_CTRL_REF_CURRENT 13

// Function code fields and codes.
`define SOS_FUNC_A_LSB 0
`define SOS_FUNC_B_LSB 8
`define SOS_FN_RUN 4'h0
`define SOS_FN_FREQ_REACHED 4'h1
`define SOS_FN_FREQ_EXCEEDED 4'h2
`define SOS_FN_OVERLOAD 4'h3
`define SOS_FN_PID_DEV 4'h4
`define SOS_FN_FAULT 4'h5
`define SOS_FN_REF_LOSS 4'h6
`define SOS_FN_FB_LIMIT 4'h7
`define SOS_FN_WATCHDOG 4'h8
`define SOS_FN_LOGIC 4'h9
`define SOS_FN_FIELDBUS 4'ha
`define SOS_FN_COUNT 11

// Logic link fields and operations.
`define SOS_LOGIC_OPA_LSB 0
`define SOS_LOGIC_OPB_LSB 8
`define SOS_LOGIC_OP_LSB 16
`define SOS_OP_AND 2'h0
`define SOS_OP_OR 2'h1
`define SOS_OP_XOR 2'h2

// Analog source codes.
`define SOS_AM_FREQ 1'b0
`define SOS_AM_CURRENT 1'b1

// Reset values.
`define SOS_RST_CTRL 32'h0000_0000
`define SOS_RST_FUNC 32'h0000_0001
`define SOS_RST_THR 32'h0000_0000
`define SOS_RST_FB_LIMIT 32'h0000_ffff
`define SOS_RST_LOGIC 32'h0000_0000
`define SOS_RST_MASK 32'h0000_0000

// Current reference loss level in microamperes (4 mA).
`define SOS_REF_LOSS_UA 16'h0fa0

// Interrupt status bits.
`define SOS_INT_OUT_A 0
`define SOS_INT_OUT_B 1
`define SOS_INT_RELAY 2
`define SOS_INT_WIDTH 3

`endif

// >>> sos_dout.v
`include "sos_map.vh"

module sos_dout #(
	parameter NCOND = `SOS_FN_COUNT
) (
	// Condition flags, one per function code.
	input wire [NCOND-1:0] cond_i,
	// Configuration.
	input wire [3:0] func_i,
	input wire break_contact_i,
	// Next output level.
	output reg level_o
);

	reg active;

	always @* begin
		active = 1'b0;
		if (func_i < NCOND) begin
			active = cond_i[func_i];
		end else begin
			active = 1'b0;
		end
		level_o = active ^ break_contact_i;
	end

endmodule // sos_dout

// >>> sos_status_output.v
// The APB slave port and the placing of the registers were left to the implementer.
`include "sos_map.vh"

module sos_status_output #(
	parameter VW = 16
) (
	// Clock and reset.
	input wire clk_sys_i,
	input wire rst_i,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Drive actual values, scaled so full range means fmax or 200 %.
	input wire [VW-1:0] output_freq_i,
	input wire [VW-1:0] motor_current_i,
	input wire [VW-1:0] freq_reference_i,
	input wire [VW-1:0] voltage_reference_i,
	input wire [VW-1:0] current_reference_input_i,
	input wire signed [VW-1:0] pid_deviation_i,
	input wire [VW-1:0] pid_feedback_i,
	// Drive status flags.
	input wire running_i,
	input wire accelerating_i,
	input wire decelerating_i,
	input wire drive_fault_i,
	input wire comm_watchdog_expired_i,
	input wire fieldbus_supply_fault_i,
	// Outputs.
	output reg [VW-1:0] measured_value_analog_out_o,
	output reg digital_out_a_o,
	output reg digital_out_b_o,
	output reg relay_fault_contact_o,
	output reg relay_healthy_contact_o,
	output reg irq_o
);

	reg [31:0] ctrl;
	reg [31:0] func;
	reg [31:0] freq_thr;
	reg [31:0] load_thr;
	reg [31:0] fb_limit;
	reg [31:0] start_freq;
	reg [31:0] logic_cfg;
	reg [`SOS_INT_WIDTH-1:0] int_status;
	reg [`SOS_INT_WIDTH-1:0] int_mask;
	reg [`SOS_INT_WIDTH-1:0] next_int_status;
	reg [`SOS_FN_COUNT-1:0] cond;
	reg [`SOS_FN_COUNT-1:0] cond_base;
	reg [VW-1:0] pid_dev_abs;
	reg logic_a;
	reg logic_b;
	reg logic_result;
	reg relay_fault_now;
	reg [31:0] read_value;
	reg read_hit;
	wire [1:0] next_dout;
	wire [3:0] func_code [0:1];
	wire [1:0] contact_type;
	wire wr_en;
	wire setup;

	localparam [31:0] RST_MASK = `SOS_RST_MASK;

	// Picks one condition flag by function code; unknown codes give zero.
	function cond_pick;
		input [`SOS_FN_COUNT-1:0] v;
		input [3:0] code;
		begin
			if (code < `SOS_FN_COUNT) begin
				cond_pick = v[code];
			end else begin
				cond_pick = 1'b0;
			end
		end
	endfunction

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;

	assign func_code[0] = func[`SOS_FUNC_A_LSB+3:`SOS_FUNC_A_LSB];
	assign func_code[1] = func[`SOS_FUNC_B_LSB+3:`SOS_FUNC_B_LSB];
	assign contact_type[0] = ctrl[`SOS_CTRL_CONTACT_A];
	assign contact_type[1] = ctrl[`SOS_CTRL_CONTACT_B];

	// Status conditions, rebuilt from the drive flags every cycle.
	always @* begin
		if (pid_deviation_i[VW-1]) begin
			pid_dev_abs = -pid_deviation_i;
		end else begin
			pid_dev_abs = pid_deviation_i;
		end
		cond_base = {`SOS_FN_COUNT{1'b0}};
		cond_base[`SOS_FN_RUN] = running_i;
		cond_base[`SOS_FN_FREQ_REACHED] = running_i &
			(output_freq_i == freq_reference_i);
		cond_base[`SOS_FN_FREQ_EXCEEDED] =
			(accelerating_i & (output_freq_i > freq_thr[VW-1:0])) |
			(decelerating_i &
			(output_freq_i > freq_thr[16+VW-1:16]));
		cond_base[`SOS_FN_OVERLOAD] =
			motor_current_i > load_thr[VW-1:0];
		cond_base[`SOS_FN_PID_DEV] =
			pid_dev_abs > load_thr[16+VW-1:16];
		cond_base[`SOS_FN_FAULT] = drive_fault_i |
			(ctrl[`SOS_CTRL_WD_FAULT] &
			comm_watchdog_expired_i);
		if (ctrl[`SOS_CTRL_REF_CURRENT]) begin
			cond_base[`SOS_FN_REF_LOSS] = running_i &
				(current_reference_input_i <
				`SOS_REF_LOSS_UA);
		end else begin
			cond_base[`SOS_FN_REF_LOSS] = running_i &
				(voltage_reference_i <
				start_freq[VW-1:0]);
		end
		cond_base[`SOS_FN_FB_LIMIT] = running_i &
			((pid_feedback_i > fb_limit[VW-1:0]) |
			(pid_feedback_i < fb_limit[16+VW-1:16]));
		cond_base[`SOS_FN_WATCHDOG] =
			comm_watchdog_expired_i;
		cond_base[`SOS_FN_FIELDBUS] =
			fieldbus_supply_fault_i;
		logic_a = cond_pick(cond_base,
			logic_cfg[`SOS_LOGIC_OPA_LSB+3:`SOS_LOGIC_OPA_LSB]);
		logic_b = cond_pick(cond_base,
			logic_cfg[`SOS_LOGIC_OPB_LSB+3:`SOS_LOGIC_OPB_LSB]);
		case (logic_cfg[`SOS_LOGIC_OP_LSB+1:`SOS_LOGIC_OP_LSB])
		`SOS_OP_AND: begin
			logic_result = logic_a & logic_b;
		end
		`SOS_OP_OR: begin
			logic_result = logic_a | logic_b;
		end
		`SOS_OP_XOR: begin
			logic_result = logic_a ^ logic_b;
		end
		default: begin
			logic_result = 1'b0;
		end
		endcase
		cond = cond_base;
		cond[`SOS_FN_LOGIC] = logic_result;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_dout
			sos_dout #(
				.NCOND(`SOS_FN_COUNT)
			) u_dout (
				.cond_i(cond),
				.func_i(func_code[gi]),
				.break_contact_i(contact_type[gi]),
				.level_o(next_dout[gi])
			);
		end
	endgenerate

	// The relay reports faults, or in general mode follows software.
	always @* begin
		if (ctrl[`SOS_CTRL_RELAY_FUNC]) begin
			relay_fault_now = ~ctrl[`SOS_CTRL_RELAY_VALUE];
		end else begin
			relay_fault_now = cond[`SOS_FN_FAULT];
		end
	end

	// Events: rising edges of the digital output levels and of the relay fault contact.
	always @* begin
		next_int_status = int_status;
		if (wr_en && paddr == `SOS_ADDR_INT_STATUS) begin
			next_int_status = int_status &
				~pwdata[`SOS_INT_WIDTH-1:0];
		end
		if (next_dout[0] & ~digital_out_a_o) begin
			next_int_status[`SOS_INT_OUT_A] = 1'b1;
		end
		if (next_dout[1] & ~digital_out_b_o) begin
			next_int_status[`SOS_INT_OUT_B] = 1'b1;
		end
		if (relay_fault_now & ~relay_fault_contact_o) begin
			next_int_status[`SOS_INT_RELAY] = 1'b1;
		end
	end

	// Read decode, captured in the setup phase.
	always @* begin
		read_hit = 1'b1;
		case (paddr)
		`SOS_ADDR_CTRL: begin
			read_value = ctrl;
		end
		`SOS_ADDR_FUNC: begin
			read_value = func;
		end
		`SOS_ADDR_FREQ_THR: begin
			read_value = freq_thr;
		end
		`SOS_ADDR_LOAD_THR: begin
			read_value = load_thr;
		end
		`SOS_ADDR_FB_LIMIT: begin
			read_value = fb_limit;
		end
		`SOS_ADDR_START_FREQ: begin
			read_value = start_freq;
		end
		`SOS_ADDR_LOGIC: begin
			read_value = logic_cfg;
		end
		`SOS_ADDR_OUT_STATE: begin
			read_value = {28'h0000000, relay_healthy_contact_o,
				relay_fault_contact_o, digital_out_b_o,
				digital_out_a_o};
		end
		`SOS_ADDR_INT_STATUS: begin
			read_value = {29'h0000000, int_status};
		end
		`SOS_ADDR_INT_MASK: begin
			read_value = {29'h0000000, int_mask};
		end
		default: begin
			read_value = 32'h0000_0000;
			read_hit = 1'b0;
		end
		endcase
	end

	// APB slave: one access cycle, answer registered at setup.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= ~read_hit;
				if (pwrite || !read_hit) begin
					prdata <= 32'h0000_0000;
				end else begin
					prdata <= read_value;
				end
			end
		end
	end

	// Software registers.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl <= `SOS_RST_CTRL;
			func <= `SOS_RST_FUNC;
			freq_thr <= `SOS_RST_THR;
			load_thr <= `SOS_RST_THR;
			fb_limit <= `SOS_RST_FB_LIMIT;
			start_freq <= `SOS_RST_THR;
			logic_cfg <= `SOS_RST_LOGIC;
			int_mask <= RST_MASK[`SOS_INT_WIDTH-1:0];
		end else if (wr_en) begin
			case (paddr)
			`SOS_ADDR_CTRL: begin
				ctrl <= pwdata & 32'h0000_3331;
			end
			`SOS_ADDR_FUNC: begin
				func <= pwdata & 32'h0000_0f0f;
			end
			`SOS_ADDR_FREQ_THR: begin
				freq_thr <= pwdata;
			end
			`SOS_ADDR_LOAD_THR: begin
				load_thr <= pwdata;
			end
			`SOS_ADDR_FB_LIMIT: begin
				fb_limit <= pwdata;
			end
			`SOS_ADDR_START_FREQ: begin
				start_freq <= pwdata & 32'h0000_ffff;
			end
			`SOS_ADDR_LOGIC: begin
				logic_cfg <= pwdata & 32'h0003_0f0f;
			end
			`SOS_ADDR_INT_MASK: begin
				int_mask <= pwdata[`SOS_INT_WIDTH-1:0];
			end
			default: begin
				ctrl <= ctrl;
			end
			endcase
		end
	end

	// Registered outputs, refreshed every cycle.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			measured_value_analog_out_o <= {VW{1'b0}};
			digital_out_a_o <= 1'b0;
			digital_out_b_o <= 1'b0;
			relay_fault_contact_o <= 1'b1;
			relay_healthy_contact_o <= 1'b0;
			int_status <= {`SOS_INT_WIDTH{1'b0}};
			irq_o <= 1'b0;
		end else begin
			if (ctrl[`SOS_CTRL_ANALOG_SEL] == `SOS_AM_CURRENT) begin
				measured_value_analog_out_o <=
					motor_current_i;
			end else begin
				measured_value_analog_out_o <=
					output_freq_i;
			end
			digital_out_a_o <= next_dout[0];
			digital_out_b_o <= next_dout[1];
			relay_fault_contact_o <= relay_fault_now;
			relay_healthy_contact_o <= ~relay_fault_now;
			int_status <= next_int_status;
			irq_o <= |(next_int_status & int_mask);
		end
	end

endmodule // sos_status_output

// >>> sos_status_output_props.sv
`include "sos_map.vh"

module sos_props (
	input wire clk_sys_i, rst_i, psel, penable, pwrite, pready,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [15:0] output_freq_i, motor_current_i,
	input wire running_i, drive_fault_i,
	input wire [15:0] measured_value_analog_out_o,
	input wire digital_out_a_o, digital_out_b_o,
	input wire relay_fault_contact_o, relay_healthy_contact_o
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [31:0] ctl;
	reg [31:0] fn;
	reg live;
	wire wr = psel && penable && pready && pwrite;
	wire [3:0] fa = fn[3:0];
	wire [3:0] fb = fn[11:8];
	// Shadow copies of the control and function registers.
	always @(posedge clk_sys_i) begin
		live <= !rst_i;
		if (rst_i) begin
			ctl <= `SOS_RST_CTRL;
			fn <= `SOS_RST_FUNC;
		end else if (wr && paddr == `SOS_ADDR_CTRL)
			ctl <= pwdata;
		else if (wr && paddr == `SOS_ADDR_FUNC)
			fn <= pwdata;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	chk_analog_src: assert property (live |->
		measured_value_analog_out_o == ($past(ctl[0]) ?
		$past(motor_current_i) : $past(output_freq_i)))
		else $error("analog output shows wrong source");
	chk_run_code: assert property (
		live && $past(fb == 0 && running_i && !ctl[5]) |-> digital_out_b_o)
		else $error("run code output inactive");
	chk_fault_code: assert property (
		live && $past(fb == 5 && drive_fault_i && !ctl[5]) |-> digital_out_b_o)
		else $error("fault code output inactive");
	chk_break_inv: assert property (
		live && $past(fa == 0 && ctl[4]) |->
		digital_out_a_o == !$past(running_i))
		else $error("break contact not inverted");
	chk_undef_idle: assert property (
		live && $past(fa > 10) |-> digital_out_a_o == $past(ctl[4]))
		else $error("undefined code output not idle");
	chk_relay_pair: assert property (
		relay_fault_contact_o != relay_healthy_contact_o)
		else $error("relay contacts not complementary");
	chk_relay_fault: assert property (
		live && $past(!ctl[8] && drive_fault_i) |-> relay_fault_contact_o)
		else $error("relay missed fault");
	chk_relay_gen: assert property (
		live && $past(ctl[8]) |-> relay_healthy_contact_o == $past(ctl[9]))
		else $error("relay general value wrong");
	cover property (digital_out_b_o && relay_fault_contact_o);
	cover property ($rose(relay_healthy_contact_o) && ctl[8]);
	cover property (live && ctl[0]);
endmodule // sos_props

bind sos_status_output sos_props sos_props_inst(.clk_sys_i, .rst_i, .psel,
	.penable, .pwrite, .pready, .paddr, .pwdata, .output_freq_i,
	.motor_current_i, .running_i, .drive_fault_i,
	.measured_value_analog_out_o, .digital_out_a_o, .digital_out_b_o,
	.relay_fault_contact_o, .relay_healthy_contact_o);

// >>> sos_far_side.sv
module sos_far_side (
	input wire clk_sys_i,
	input wire coil_b_i,
	input wire fault_i,
	input wire healthy_i,
	output reg lamp_b_o,
	output reg [1:0] contacts_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Contacts follow their coil drive one clock later.
	always @(posedge clk_sys_i) begin
		lamp_b_o <= coil_b_i;
		contacts_o <= {fault_i, healthy_i};
	end
endmodule // sos_far_side

// >>> tb.sv
`include "sos_map.vh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, err, irq_o, lamp_b;
	logic [1:0] cts;
	logic [15:0] output_freq_i = 0, motor_current_i = 0;
	logic [15:0] freq_reference_i = 0, voltage_reference_i = 0;
	logic [15:0] current_reference_input_i = 0, pid_feedback_i = 0;
	logic signed [15:0] pid_deviation_i = 0;
	logic running_i = 0, accelerating_i = 0, decelerating_i = 0;
	logic drive_fault_i = 0, comm_watchdog_expired_i = 0;
	logic fieldbus_supply_fault_i = 0;
	logic [15:0] measured_value_analog_out_o;
	logic digital_out_a_o, digital_out_b_o;
	logic relay_fault_contact_o, relay_healthy_contact_o;
	int err_count = 0, num_checks = 0;

	sos_status_output sos_status_output_inst(.clk_sys_i, .rst_i, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.output_freq_i, .motor_current_i, .freq_reference_i,
		.voltage_reference_i, .current_reference_input_i,
		.pid_deviation_i, .pid_feedback_i, .running_i, .accelerating_i,
		.decelerating_i, .drive_fault_i, .comm_watchdog_expired_i,
		.fieldbus_supply_fault_i, .measured_value_analog_out_o,
		.digital_out_a_o, .digital_out_b_o, .relay_fault_contact_o,
		.relay_healthy_contact_o, .irq_o);
	sos_far_side sos_far_side_inst(.clk_sys_i, .coil_b_i(digital_out_b_o),
		.fault_i(relay_fault_contact_o), .healthy_i(relay_healthy_contact_o),
		.lamp_b_o(lamp_b), .contacts_o(cts));

	initial forever #10 clk_sys_i = ~clk_sys_i;

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1;
		do begin
			@(posedge clk_sys_i);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wrap_up;
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task t_regs;
		apb(0, `SOS_ADDR_CTRL, 0);
		chk(rd, `SOS_RST_CTRL);
		apb(0, `SOS_ADDR_FUNC, 0);
		chk(rd, `SOS_RST_FUNC);
		apb(0, `SOS_ADDR_FB_LIMIT, 0);
		chk(rd, `SOS_RST_FB_LIMIT);
		apb(0, 8'hfc, 0);
		chk(err, 1);
		chk(rd, 0);
	endtask
	task t_analog;
		@(posedge clk_sys_i);
		output_freq_i <= 16'h1234;
		motor_current_i <= 16'habcd;
		cyc(3);
		chk(measured_value_analog_out_o, 16'h1234);
		apb(1, `SOS_ADDR_CTRL, 1);
		cyc(3);
		chk(measured_value_analog_out_o, 16'habcd);
	endtask
	// One input set makes code k true when on is set, false otherwise.
	task stim(input logic [3:0] k, input logic on);
		@(posedge clk_sys_i);
		running_i <= (k == 0 || k == 9) ? on : (k == 1 || k == 6 || k == 7);
		accelerating_i <= k == 2;
		output_freq_i <= (k == 1 || k == 2 && on) ? 16'h5 : 16'h0;
		freq_reference_i <= on ? 16'h5 : 16'h6;
		motor_current_i <= (k == 3 && on) ? 16'h1 : 16'h0;
		pid_deviation_i <= (k == 4 && on) ? 16'h1 : 16'h0;
		drive_fault_i <= k == 5 && on;
		voltage_reference_i <= (k == 6 && on) ? 16'h0 : 16'h1;
		pid_feedback_i <= (k == 7 && on) ? 16'hb : 16'ha;
		comm_watchdog_expired_i <= k == 8 && on;
		fieldbus_supply_fault_i <= k == 10 && on;
	endtask
	task t_codes;
		logic [3:0] k;
		logic e;
		apb(1, `SOS_ADDR_START_FREQ, 1);
		apb(1, `SOS_ADDR_FB_LIMIT, 32'h0000_000a);
		apb(1, `SOS_ADDR_CTRL, 32'h10);
		for (int c = 0; c < 12; c++) begin
			k = c < 11 ? c[3:0] : 4'hf;
			apb(1, `SOS_ADDR_FUNC, {20'h0, k, 4'h0, k});
			for (int on = 1; on >= 0; on--) begin
				stim(k, on[0]);
				cyc(3);
				e = on[0] && c < 11;
				chk(lamp_b, e);
				chk(digital_out_a_o, !e);
			end
		end
	endtask
	task t_logic;
		apb(1, `SOS_ADDR_FUNC, 32'h0909);
		for (int op = 0; op < 3; op++) begin
			apb(1, `SOS_ADDR_LOGIC, {14'h0, op[1:0], 16'h0805});
			for (int w = 0; w < 2; w++) begin
				stim(5, 1);
				@(posedge clk_sys_i);
				comm_watchdog_expired_i <= w[0];
				cyc(3);
				chk(digital_out_b_o, op == 0 ? w : op == 1 ? 1 : !w);
			end
		end
	endtask
	task t_relay;
		for (int m = 0; m < 4; m++) begin
			apb(1, `SOS_ADDR_CTRL, m == 1 ? 32'h300 : m == 2 ? 32'h100 : 0);
			stim(0, 0);
			@(posedge clk_sys_i);
			drive_fault_i <= m != 3;
			cyc(4);
			chk(cts, m == 1 ? 2'b01 : m == 2 ? 2'b10 : m == 0 ? 2'b10 : 2'b01);
		end
	endtask
	task t_irq;
		apb(1, `SOS_ADDR_FUNC, 32'h0500);
		stim(0, 0);
		cyc(3);
		apb(1, `SOS_ADDR_INT_STATUS, 32'h7);
		stim(5, 1);
		cyc(3);
		chk(irq_o, 0);
		apb(0, `SOS_ADDR_INT_STATUS, 0);
		chk(rd, 32'h6);
		apb(0, `SOS_ADDR_OUT_STATE, 0);
		chk(rd, 32'h6);
		apb(1, `SOS_ADDR_INT_MASK, 32'h2);
		cyc(2);
		chk(irq_o, 1);
		apb(1, `SOS_ADDR_INT_STATUS, 32'h6);
		cyc(2);
		chk(irq_o, 0);
		apb(0, `SOS_ADDR_INT_STATUS, 0);
		chk(rd, 0);
	endtask
	// Watchdog as fault, current reference loss, deceleration threshold.
	task t_modes;
		apb(1, `SOS_ADDR_CTRL, 32'h3000);
		apb(1, `SOS_ADDR_FUNC, 32'h0605);
		apb(1, `SOS_ADDR_FREQ_THR, 32'h0004_0009);
		stim(6, 0);
		for (int on = 1; on >= 0; on--) begin
			@(posedge clk_sys_i);
			comm_watchdog_expired_i <= on[0];
			current_reference_input_i <= on[0] ? 16'h0f9f : 16'h0fa0;
			cyc(3);
			chk(digital_out_a_o, on[0]);
			chk(lamp_b, on[0]);
		end
		apb(1, `SOS_ADDR_FUNC, 32'h0002);
		for (int on = 1; on >= 0; on--) begin
			@(posedge clk_sys_i);
			accelerating_i <= !on[0];
			decelerating_i <= on[0];
			output_freq_i <= 16'h5;
			cyc(3);
			chk(digital_out_a_o, on[0]);
		end
	endtask

	initial begin
		cyc(7);
		chk({measured_value_analog_out_o, digital_out_a_o, digital_out_b_o,
			relay_fault_contact_o, relay_healthy_contact_o}, 20'h00002);
		@(posedge clk_sys_i);
		rst_i <= 0;
		t_regs;
		t_analog;
		t_codes;
		t_logic;
		t_relay;
		t_irq;
		t_modes;
		wrap_up;
	end
	initial begin
		#200000;
		err_count++;
		wrap_up;
	end
endmodule // tb
